// >>> rtl/uirq_top.sv
`timescale 1ns/1ps
module uirq_top
(
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 ce_in,
    input  wire logic [2:0]           addr_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic [7:0]           fcr_in,
    input  wire uirq_pkg::uirq_stat_t stat_in,
    output logic      [7:0]           rdata_out,
    output logic      [7:0]           mask_out,
    output logic      [7:0]           line_out,
    output logic      [3:0]           source_out,
    output logic                      sleep_out,
    output logic                      low_power_out,
    output logic                      irq_out
);
    import uirq_pkg::*;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire logic       mask_wr;
    wire logic       fifo_on;
    wire logic       at_trigger;
    wire logic       rx_pend;
    wire logic       tx_pend;
    wire logic       line_pend;
    wire logic       modem_pend;
    wire logic [3:0] next_source;
    wire logic [7:0] next_rdata;
    logic            line_event;
    logic            modem_event;

    assign mask_wr = wr_in && (addr_in == ADDR_MASK);
    assign fifo_on = fcr_in[FCR_FIFO_EN];                      // [RULE16]

    uirq_mask_reg u_mask
    (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .ce_in    (ce_in),
        .wr_in    (mask_wr),
        .data_in  (wdata_in),
        .mask_out (mask_out)
    );

    uirq_line_status u_line
    (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .ce_in    (ce_in),
        .stat_in  (stat_in),
        .line_out (line_out)
    );

    // ------------------------------------------------------------
    // interrupt sources
    // ------------------------------------------------------------
    // trigger level reached while fifo on; else any held byte
    assign at_trigger = fifo_on ? (stat_in.rx_count >= stat_in.trig_level)
                                : (stat_in.rx_count != '0);   // [RULE17]
    assign rx_pend    = mask_out[BIT_RX_READY] && at_trigger;  // [RULE6]
    assign tx_pend    = mask_out[BIT_TX_EMPTY]
                        && stat_in.tx_fifo_empty;             // [RULE5]
    assign line_pend  = mask_out[BIT_LINE_STAT] && line_event; // [RULE4]
    assign modem_pend = mask_out[BIT_MODEM] && modem_event;    // [RULE3]

    // priority: line, receive, transmit, modem
    assign next_source = line_pend  ? SRC_LINE  :
                         rx_pend    ? SRC_RX    :              // [RULE9]
                         tx_pend    ? SRC_TX    :
                         modem_pend ? SRC_MODEM : SRC_NONE;

    // sticky events cleared by reading the source register;
    // a new event in the clearing cycle wins
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            line_event  <= 1'b0;
            modem_event <= 1'b0;
        end
        else if (ce_in)
        begin
            line_event  <= stat_in.rx_load
                || (line_event && !(rd_in && addr_in == ADDR_SOURCE));
            modem_event <= stat_in.modem_change
                || (modem_event && !(rd_in && addr_in == ADDR_SOURCE));
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    assign next_rdata = (addr_in == ADDR_MASK)   ? mask_out :
                        (addr_in == ADDR_SOURCE) ?
                            {fifo_on, fifo_on, 2'b00, source_out} :
                        (addr_in == ADDR_LINE)   ? line_out : 8'h00;

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            source_out    <= SRC_NONE;
            irq_out       <= 1'b0;
            sleep_out     <= 1'b0;
            low_power_out <= 1'b0;
            rdata_out     <= 8'h00;
        end
        else if (ce_in)
        begin
            source_out    <= next_source;                      // [RULE9]
            irq_out       <= rx_pend | tx_pend |
                             line_pend | modem_pend;           // [RULE8] [RULE18]
            sleep_out     <= mask_out[BIT_SLEEP];              // [RULE2]
            low_power_out <= mask_out[BIT_LOW_POWER];          // [RULE1]
            rdata_out     <= rd_in ? next_rdata : rdata_out;
        end
    end
endmodule // uirq_top

// >>> rtl/uirq_pkg.sv
// What this block does
// (RULE1) mask bit 5 selects low-power operation
// (RULE2) mask bit 4 selects sleep operation
// (RULE3) mask bit 3 gates modem-status interrupt
// (RULE4) mask bit 2 gates receive line status
// (RULE5) mask bit 1 gates transmitter-empty interrupt
// (RULE6) mask bit 0 gates receive trigger interrupt
// (RULE7) mask register resets to zero, bits 7-6 unused
// (RULE8) enabled pending interrupts drive one output pin
// (RULE9) source register shows trigger, clears with it
// (RULE10) data-ready set on load, cleared when empty
// (RULE11) host polls status with mask bits 0-3 cleared
// (RULE12) status bits 1-4 report receive error types
// (RULE13) status bit 5: transmit fifo empty
// (RULE14) status bit 6: transmit fifo and shifter empty
// (RULE15) status bit 7: error held in receive fifo
// (RULE16) fifo control bit 0 enables both fifos
// (RULE17) trigger when count equals programmed level; the code also triggers when the count is above it
// (RULE18) interrupt asserts while any enabled source pends
package uirq_pkg;

    // ------------------------------------------------------------
    // register addresses (a2..a0)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_MASK   = 3'h1;
    localparam logic [2:0] ADDR_SOURCE = 3'h2;
    localparam logic [2:0] ADDR_LINE   = 3'h5;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         BIT_RX_READY  = 0;
    localparam int         BIT_TX_EMPTY  = 1;
    localparam int         BIT_LINE_STAT = 2;
    localparam int         BIT_MODEM     = 3;
    localparam int         BIT_SLEEP     = 4;
    localparam int         BIT_LOW_POWER = 5;
    localparam int         MASK_USED     = 6;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [7:0] LINE_RESET    = 8'h60;
    localparam int         FCR_FIFO_EN   = 0;
    localparam int         FIFO_DEPTH    = 64;
    localparam int         CNT_W         = 7;

    // interrupt identity codes shown in the source register
    localparam logic [3:0] SRC_NONE  = 4'h1;
    localparam logic [3:0] SRC_LINE  = 4'h6;
    localparam logic [3:0] SRC_RX    = 4'h4;
    localparam logic [3:0] SRC_TX    = 4'h2;
    localparam logic [3:0] SRC_MODEM = 4'h0;

    // status from the fifo and shifter logic
    typedef struct packed {
        logic [CNT_W-1:0] rx_count;
        logic [CNT_W-1:0] trig_level;
        logic             rx_load;
        logic             tx_fifo_empty;
        logic             tx_shift_empty;
        logic [3:0]       rx_errors;    // break, framing, parity, overrun
        logic             rx_fifo_error;
        logic             modem_change;
    } uirq_stat_t;

    typedef enum logic [1:0] {
        UIRQ_RUN   = 2'b00,
        UIRQ_SLEEP = 2'b01,
        UIRQ_LOWP  = 2'b10
    } uirq_pwr_t;

endpackage : uirq_pkg

// >>> rtl/uirq_mask_reg.sv
`timescale 1ns/1ps
module uirq_mask_reg
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       ce_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] data_in,
    output logic      [7:0] mask_out
);
    import uirq_pkg::*;

    // ------------------------------------------------------------
    // mask register, upper two bits never stored
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            mask_out <= MASK_RESET;                          // [RULE7]
        else if (ce_in && wr_in)
            mask_out <= {2'b00, data_in[MASK_USED-1:0]};    // [RULE7]
    end
endmodule // uirq_mask_reg

// >>> rtl/uirq_line_status.sv
`timescale 1ns/1ps
module uirq_line_status
(
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 ce_in,
    input  wire uirq_pkg::uirq_stat_t stat_in,
    output logic      [7:0]           line_out
);
    import uirq_pkg::*;

    wire logic data_ready;
    // data ready follows the fifo count; a load makes it immediate
    assign data_ready = (stat_in.rx_count != '0)
                        || stat_in.rx_load;                  // [RULE10]

    // ------------------------------------------------------------
    // registered line status image
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            line_out <= LINE_RESET;
        else if (ce_in)
            line_out <= {stat_in.rx_fifo_error,                      // [RULE15]
                         stat_in.tx_fifo_empty &
                         stat_in.tx_shift_empty,                     // [RULE14]
                         stat_in.tx_fifo_empty,                      // [RULE13]
                         stat_in.rx_errors,                          // [RULE12]
                         data_ready};
    end
endmodule // uirq_line_status

// >>> dv/uirq_chk_assertions.sv
`timescale 1ns/1ps
module uirq_chk
(
    input wire logic                 clk_in,
    input wire logic                 nrst_in,
    input wire logic                 ce_in,
    input wire logic [2:0]           addr_in,
    input wire logic                 wr_in,
    input wire logic                 rd_in,
    input wire logic [7:0]           wdata_in,
    input wire logic [7:0]           fcr_in,
    input wire uirq_pkg::uirq_stat_t stat_in,
    input wire logic [7:0]           rdata_out,
    input wire logic [7:0]           mask_out,
    input wire logic [7:0]           line_out,
    input wire logic [3:0]           source_out,
    input wire logic                 sleep_out,
    input wire logic                 low_power_out,
    input wire logic                 irq_out
);
    import uirq_pkg::*;
    // everything here lives in the one clock domain
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // fifo at or over trigger with the receive source enabled
    sequence s_trig;
        (fcr_in[0] && mask_out[0]
            && stat_in.rx_count >= stat_in.trig_level)[*3];
    endsequence
    property p_unused; mask_out[7:6] == 2'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused set");
    property p_wr; ce_in && wr_in && addr_in == ADDR_MASK |=>
        mask_out == {2'h0, $past(wdata_in[5:0])}; endproperty
    a_wr: assert property (p_wr) else $error("mask write");
    property p_slp; $rose(mask_out[4]) |-> ##[0:1] sleep_out; endproperty
    a_slp: assert property (p_slp) else $error("sleep");
    property p_quiet; (mask_out[3:0] == 4'h0)[*3] |-> !irq_out; endproperty
    a_quiet: assert property (p_quiet) else $error("irq masked");
    property p_src; irq_out == (source_out != SRC_NONE); endproperty
    a_src: assert property (p_src) else $error("irq vs source");
    property p_trig; s_trig |-> irq_out; endproperty
    a_trig: assert property (p_trig) else $error("trigger");
    property p_below; (fcr_in[0] && mask_out[3:0] == 4'h1
        && stat_in.rx_count < stat_in.trig_level)[*3] |-> !irq_out;
    endproperty
    a_below: assert property (p_below) else $error("below");
    property p_temt; (!stat_in.tx_shift_empty)[*2] |-> !line_out[6];
    endproperty
    a_temt: assert property (p_temt) else $error("shifter");
    property p_dr; (stat_in.rx_count != 7'h0)[*2] |-> line_out[0];
    endproperty
    a_dr: assert property (p_dr) else $error("data ready");
endmodule // uirq_chk
bind uirq_top uirq_chk u_chk (.*);

// >>> dv/uirq_host.sv
`timescale 1ns/1ps
module uirq_host
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic            ce_out,
    output logic [2:0]      addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output logic [7:0]      wdata_out
);
    // strobes idle low; data shows the inverse of the last value
    initial {ce_out, addr_out, wr_out, rd_out, wdata_out} = {1'b1, 13'h0};
    // write held across the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    // polled status read, no interrupt needed
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_in);
        {addr_out, rd_out} = {a, 1'b1};
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
    // clock enable, changed off the sampling edge
    task automatic hold(input logic v);
        @(negedge clk_in);
        ce_out = v;
    endtask
endmodule // uirq_host

// >>> dv/uirq_tb_top.sv
`timescale 1ns/1ps
module uirq_tb_top;
    import uirq_pkg::*;
    logic clk_in, nrst_in, ce, wr, rd, slp, lowp, irq;
    logic [2:0] addr;
    logic [3:0] src;
    logic [7:0] wdata, fifo_control_reg, rdata, mask, line, d;
    uirq_stat_t st;
    int n_errors = 0;
    int checks = 0;
    uirq_host HOST (.clk_in(clk_in), .rdata_in(rdata), .ce_out(ce),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    uirq_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
        .addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wdata),
        .fcr_in(fifo_control_reg), .stat_in(st), .rdata_out(rdata), .mask_out(mask),
        .line_out(line), .source_out(src), .sleep_out(slp),
        .low_power_out(lowp), .irq_out(irq));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // reset image, unused bits, refused write, power modes
    task automatic t_mask;
        HOST.rd(ADDR_MASK, d);
        chk(d, MASK_RESET);
        chk({3'h0, irq, src}, {4'h0, SRC_NONE});
        HOST.wr(ADDR_MASK, 8'hFF);
        HOST.wr(3'h0, 8'h00);
        HOST.rd(ADDR_MASK, d);
        chk(d, 8'h3F);
        chk({6'h0, lowp, slp}, 8'h03);
        HOST.wr(ADDR_MASK, 8'h00);
        cyc(2);
        chk({6'h0, lowp, slp}, 8'h00);
        // a write with the clock enable low must not land
        HOST.wr(ADDR_MASK, 8'h3F);
        HOST.hold(1'b0);
        HOST.wr(ADDR_MASK, 8'h00);
        HOST.hold(1'b1);
        chk(mask, 8'h3F);
        // reset in mid-run clears the mask and both power modes
        nrst_in = 1'b0;
        cyc(3);
        nrst_in = 1'b1;
        chk(mask, MASK_RESET);
        chk({6'h0, lowp, slp}, 8'h00);
    endtask
    // receive trigger: below, at, then back below
    task automatic t_trig;
        fifo_control_reg = 8'h01;
        st.trig_level = 7'h08;
        st.rx_count = 7'h07;
        HOST.wr(ADDR_MASK, 8'h01);
        cyc(3);
        chk({3'h0, irq, src}, {4'h0, SRC_NONE});
        st.rx_count = 7'h08;
        cyc(3);
        chk({3'h0, irq, src}, {4'h1, SRC_RX});
        chk({7'h0, line[0]}, 8'h01);
        st.rx_count = 7'h07;
        cyc(3);
        chk({3'h0, irq, src}, {4'h0, SRC_NONE});
        // fifos off: any held byte is enough for the receive source
        fifo_control_reg = 8'h00;
        cyc(3);
        chk({3'h0, irq, src}, {4'h1, SRC_RX});
        fifo_control_reg = 8'h01;
        st.rx_count = 7'h00;
    endtask
    // transmitter empty source and its status bits
    task automatic t_tx;
        st.tx_shift_empty = 1'b0;
        HOST.wr(ADDR_MASK, 8'h02);
        cyc(3);
        chk({line[7:5], irq, src}, {4'h3, SRC_TX});
        st.tx_fifo_empty = 1'b0;
        cyc(3);
        chk({line[7:5], irq, src}, {4'h0, SRC_NONE});
        st.tx_fifo_empty = 1'b1;
        st.tx_shift_empty = 1'b1;
    endtask
    // one-cycle event pulse, serviced by reading the source register
    task automatic t_event(input logic [7:0] m, input logic [3:0] code);
        HOST.wr(ADDR_MASK, m);
        st.rx_errors = 4'hF;
        st.rx_fifo_error = 1'b1;
        st.rx_load = 1'b1;
        st.modem_change = 1'b1;
        cyc(1);
        // load and modem change are pulses; error flags are levels
        st.rx_load = 1'b0;
        st.modem_change = 1'b0;
        cyc(2);
        chk({line[7:1], irq}, 8'hFF);
        chk({3'h0, irq, src}, {4'h1, code});
        st = '{tx_fifo_empty: 1'b1, tx_shift_empty: 1'b1, default: '0};
        HOST.rd(ADDR_SOURCE, d);
        chk(d, {fifo_control_reg[0], fifo_control_reg[0], 2'b00, code});
        cyc(3);
        chk({7'h0, irq}, 8'h00);
    endtask
    // polled use: trigger reached, interrupts masked, status visible
    task automatic t_poll;
        HOST.wr(ADDR_MASK, 8'h00);
        st.trig_level = 7'h08;
        st.rx_count = 7'h08;
        cyc(3);
        chk({7'h0, irq}, 8'h00);
        HOST.rd(ADDR_LINE, d);
        chk(d, 8'h61);
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        nrst_in = 1'b0;
        fifo_control_reg = 8'h00;
        st = '{tx_fifo_empty: 1'b1, tx_shift_empty: 1'b1, default: '0};
        cyc(3);
        nrst_in = 1'b1;
        chk(line, 8'h60);
        t_mask;
        t_trig;
        t_tx;
        t_event(8'h04, SRC_LINE);
        t_event(8'h08, SRC_MODEM);
        t_poll;
        print_verdict;
    end
endmodule // uirq_tb_top
